// >>> ccpts_pkg.sv
// Shared constants, field layouts, carriers and decode helpers for ccpts
package ccpts_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CCPTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] CCPTS_FLAG_OFS = 8'h04;
  localparam logic [7:0] CCPTS_VAL1_OFS = 8'h08;
  localparam logic [7:0] CCPTS_VAL2_OFS = 8'h0c;
  localparam logic [7:0] CCPTS_STAT_OFS = 8'h10;

  // Control register field positions
  localparam int CCPTS_MODE1_LSB = 0;
  localparam int CCPTS_MODE2_LSB = 4;
  localparam int CCPTS_SEL1_BIT = 8;
  localparam int CCPTS_SEL2_BIT = 9;
  localparam int CCPTS_ROUTE_BIT = 10;

  // Flag register field positions
  localparam int CCPTS_FLAG1_BIT = 0;
  localparam int CCPTS_FLAG2_BIT = 1;

  // Values after reset
  localparam logic [3:0] CCPTS_MODE_RST = 4'h0;
  localparam logic CCPTS_SEL_RST = 1'b0;
  localparam logic CCPTS_ROUTE_RST = 1'b1;
  localparam logic [15:0] CCPTS_VAL_RST = 16'h0000;
  localparam logic [31:0] CCPTS_WORD_ZERO = 32'h0000_0000;

  // Mode field encodings
  localparam logic [3:0] CCPTS_MODE_OFF = 4'h0;
  localparam logic [3:0] CCPTS_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] CCPTS_CAP_FALL = 4'h4;
  localparam logic [3:0] CCPTS_CAP_RISE = 4'h5;
  localparam logic [3:0] CCPTS_CAP_DIV4 = 4'h6;
  localparam logic [3:0] CCPTS_CAP_DIV16 = 4'h7;
  localparam logic [3:0] CCPTS_CMP_TRIG = 4'hb;

  // Prescaler: last count before a strobe, counter wraps to zero
  localparam logic [3:0] CCPTS_PRE_RST = 4'h0;
  localparam logic [3:0] CCPTS_PRE_DIV4_LAST = 4'h3;
  localparam logic [3:0] CCPTS_PRE_DIV16_LAST = 4'hf;

  // AHB-Lite encodings
  localparam logic [2:0] CCPTS_HSIZE_WORD = 3'b010;
  localparam logic CCPTS_HRESP_OKAY = 1'b0;

  // One port pin as seen by a unit: pad, output latch, direction
  typedef struct packed {
    logic pad;
    logic latch;
    logic dir_out;
  } ccpts_pin_type;

  // Timer reset, ADC start and PWM update signals leaving the block
  typedef struct packed {
    logic timer_one_reset;
    logic timer_three_reset;
    logic adc_start;
    logic pwm_period_update;
  } ccpts_trig_type;

  function automatic logic ccpts_is_capture(input logic [3:0] mode);
    return mode[3:2] == 2'b01;
  endfunction

  function automatic logic ccpts_is_compare(input logic [3:0] mode);
    return (mode == CCPTS_CMP_TOGGLE) || (mode[3:2] == 2'b10);
  endfunction

  function automatic logic ccpts_is_pwm(input logic [3:0] mode);
    return mode[3:2] == 2'b11;
  endfunction

  // An output-driven pin shows its own latch to the unit
  function automatic logic ccpts_pin_level(input ccpts_pin_type pin);
    return pin.dir_out ? pin.latch : pin.pad;
  endfunction

endpackage

// >>> ccpts_capture_unit.sv
// Pin synchroniser, edge detector and capture prescaler for one unit
`timescale 1ns/10ps
module ccpts_capture_unit #(
  parameter int PRE_WIDTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] mode,
  input wire logic pin_level,
  output logic capture_strobe
);
  import ccpts_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [3:0] cnt;
    logic strobe;
  } ccpts_cap_state_type;

  ccpts_cap_state_type state_ff;
  ccpts_cap_state_type nxt_state;
  logic rise;
  logic fall;

  // Elaboration check: the prescaler logic is built for four bits only
  if (PRE_WIDTH != 4) begin : g_width_check
    $error("ccpts_capture_unit needs a four bit prescaler");
  end

  // Edges come only from the second stage, never the first
  assign rise = state_ff.sync2 & ~state_ff.prev;
  assign fall = ~state_ff.sync2 & state_ff.prev;

  // Next state of synchroniser, prescaler and strobe
  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync1 = pin_level;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev = state_ff.sync2;
    nxt_state.strobe = 1'b0;
    if (!ccpts_is_capture(mode)) begin
      nxt_state.cnt = CCPTS_PRE_RST;
    end else begin
      case (mode)
        CCPTS_CAP_FALL: begin
          nxt_state.strobe = fall;
        end
        CCPTS_CAP_RISE: begin
          nxt_state.strobe = rise;
        end
        CCPTS_CAP_DIV4: begin
          if (rise) begin
            if (state_ff.cnt >= CCPTS_PRE_DIV4_LAST) begin
              nxt_state.cnt = CCPTS_PRE_RST;
              nxt_state.strobe = 1'b1;
            end else begin
              nxt_state.cnt = state_ff.cnt + 4'h1;
            end
          end
        end
        CCPTS_CAP_DIV16: begin
          if (rise) begin
            nxt_state.cnt = state_ff.cnt + 4'h1;
            nxt_state.strobe = (state_ff.cnt == CCPTS_PRE_DIV16_LAST);
          end
        end
        default: begin
          nxt_state.cnt = CCPTS_PRE_RST;
        end
      endcase
    end
  end

  // State register; reset clears the prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign capture_strobe = state_ff.strobe;

endmodule

// >>> ccpts_top.sv
// Two unit capture and timer select block with an AHB-Lite register slave
`timescale 1ns/10ps
module ccpts_top #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ccpts_pkg::ccpts_pin_type unit_one_pin,
  input wire ccpts_pkg::ccpts_pin_type primary_port_pin,
  input wire ccpts_pkg::ccpts_pin_type alternate_port_pin,
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_three_count,
  input wire logic timer_two_period,
  output ccpts_pkg::ccpts_trig_type trig,
  output logic unit_one_event_flag,
  output logic unit_two_event_flag
);
  import ccpts_pkg::*;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] addr;
    logic [3:0] mode1;
    logic [3:0] mode2;
    logic sel1;
    logic sel2;
    logic route;
    logic flag1;
    logic flag2;
    logic [15:0] val1;
    logic [15:0] val2;
    logic match1;
    logic match2;
    ccpts_trig_type trig;
  } ccpts_state_type;

  ccpts_state_type state_ff;
  ccpts_state_type nxt_state;
  logic cap1;
  logic cap2;
  logic lvl1;
  logic lvl2;
  logic [15:0] tbase1;
  logic [15:0] tbase2;
  logic take;
  logic hit1;
  logic hit2;
  logic ev1;
  logic ev2;
  logic clr1;
  logic clr2;

  // Elaboration check: the offset decoder reads eight address bits
  if (ADDR_WIDTH != 8) begin : g_addr_check
    $error("ccpts_top decodes exactly eight address bits");
  end

  // Time base for a unit: select bit high means timer three
  function automatic logic [15:0] ccpts_timebase(input logic sel);
    return sel ? timer_three_count : timer_one_count;
  endfunction

  // Register read mux, unmapped offsets read zero
  function automatic logic [31:0] ccpts_read(input logic [7:0] ofs);
    logic [31:0] w;
    w = CCPTS_WORD_ZERO;
    case (ofs)
      CCPTS_CTRL_OFS: begin
        w[CCPTS_MODE1_LSB +: 4] = state_ff.mode1;
        w[CCPTS_MODE2_LSB +: 4] = state_ff.mode2;
        w[CCPTS_SEL1_BIT] = state_ff.sel1;
        w[CCPTS_SEL2_BIT] = state_ff.sel2;
        w[CCPTS_ROUTE_BIT] = state_ff.route;
      end
      CCPTS_FLAG_OFS: begin
        w[CCPTS_FLAG1_BIT] = state_ff.flag1;
        w[CCPTS_FLAG2_BIT] = state_ff.flag2;
      end
      CCPTS_VAL1_OFS: begin
        w[15:0] = state_ff.val1;
      end
      CCPTS_VAL2_OFS: begin
        w[15:0] = state_ff.val2;
      end
      CCPTS_STAT_OFS: begin
        w[0] = ccpts_is_capture(state_ff.mode1);
        w[1] = ccpts_is_capture(state_ff.mode2);
        w[2] = ccpts_is_compare(state_ff.mode1);
        w[3] = ccpts_is_compare(state_ff.mode2);
        w[4] = ccpts_is_pwm(state_ff.mode1);
        w[5] = ccpts_is_pwm(state_ff.mode2);
      end
      default: begin
        w = CCPTS_WORD_ZERO;
      end
    endcase
    return w;
  endfunction

  assign lvl1 = ccpts_pin_level(unit_one_pin);
  assign lvl2 = state_ff.route ? ccpts_pin_level(primary_port_pin)
                               : ccpts_pin_level(alternate_port_pin);

  assign tbase1 = ccpts_timebase(state_ff.sel1);
  assign tbase2 = ccpts_timebase(state_ff.sel2);

  // Edge and prescale logic per unit
  ccpts_capture_unit #(
    .PRE_WIDTH(4)
  ) u_cap1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(state_ff.mode1),
    .pin_level(lvl1),
    .capture_strobe(cap1)
  );

  ccpts_capture_unit #(
    .PRE_WIDTH(4)
  ) u_cap2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(state_ff.mode2),
    .pin_level(lvl2),
    .capture_strobe(cap2)
  );

  // Compare match; an edge of it fires once even if the timer stalls
  assign hit1 = ccpts_is_compare(state_ff.mode1) && (state_ff.val1 == tbase1);
  assign hit2 = ccpts_is_compare(state_ff.mode2) && (state_ff.val2 == tbase2);
  assign ev1 = hit1 & ~state_ff.match1;
  assign ev2 = hit2 & ~state_ff.match2;

  // Flag clears by writing one to the flag word in a data phase
  assign clr1 = state_ff.wr_pend && (state_ff.addr == CCPTS_FLAG_OFS)
                && hwdata[CCPTS_FLAG1_BIT];
  assign clr2 = state_ff.wr_pend && (state_ff.addr == CCPTS_FLAG_OFS)
                && hwdata[CCPTS_FLAG2_BIT];

  // Address phase accepted; only word transfers write
  assign take = hsel && htrans[1] && hready;

  // Next state of bus slave, registers and triggers
  always_comb begin
    nxt_state = state_ff;
    nxt_state.hreadyout = 1'b1;
    nxt_state.hresp = CCPTS_HRESP_OKAY;
    nxt_state.match1 = hit1;
    nxt_state.match2 = hit2;

    // Data phase of a write lands here
    if (state_ff.wr_pend) begin
      case (state_ff.addr)
        CCPTS_CTRL_OFS: begin
          nxt_state.mode1 = hwdata[CCPTS_MODE1_LSB +: 4];
          nxt_state.mode2 = hwdata[CCPTS_MODE2_LSB +: 4];
          nxt_state.sel1 = hwdata[CCPTS_SEL1_BIT];
          nxt_state.sel2 = hwdata[CCPTS_SEL2_BIT];
          nxt_state.route = hwdata[CCPTS_ROUTE_BIT];
        end
        CCPTS_VAL1_OFS: begin
          nxt_state.val1 = hwdata[15:0];
        end
        CCPTS_VAL2_OFS: begin
          nxt_state.val2 = hwdata[15:0];
        end
        default: begin
          nxt_state.wr_pend = 1'b0;
        end
      endcase
    end

    // Address phase: latch target and prepare read data
    nxt_state.wr_pend = take && hwrite && (hsize == CCPTS_HSIZE_WORD);
    if (take) begin
      nxt_state.addr = haddr[7:0];
      nxt_state.hrdata = hwrite ? CCPTS_WORD_ZERO : ccpts_read(haddr[7:0]);
    end

    if (clr1) begin
      nxt_state.flag1 = 1'b0;
    end
    if (clr2) begin
      nxt_state.flag2 = 1'b0;
    end

    if (cap1) begin
      nxt_state.val1 = tbase1;
    end
    if (cap2) begin
      nxt_state.val2 = tbase2;
    end

    if (cap1 || ev1) begin
      nxt_state.flag1 = 1'b1;
    end
    if (cap2 || ev2) begin
      nxt_state.flag2 = 1'b1;
    end

    nxt_state.trig.timer_one_reset =
      (ev1 && (state_ff.mode1 == CCPTS_CMP_TRIG) && !state_ff.sel1) ||
      (ev2 && (state_ff.mode2 == CCPTS_CMP_TRIG) && !state_ff.sel2);
    nxt_state.trig.timer_three_reset =
      (ev1 && (state_ff.mode1 == CCPTS_CMP_TRIG) && state_ff.sel1) ||
      (ev2 && (state_ff.mode2 == CCPTS_CMP_TRIG) && state_ff.sel2);
    nxt_state.trig.adc_start = ev2 && (state_ff.mode2 == CCPTS_CMP_TRIG);
    nxt_state.trig.pwm_period_update = timer_two_period &&
      (ccpts_is_pwm(state_ff.mode1) || ccpts_is_pwm(state_ff.mode2));

    if (state_ff.mode1 == CCPTS_MODE_OFF) begin
      nxt_state.match1 = 1'b0;
    end
    if (state_ff.mode2 == CCPTS_MODE_OFF) begin
      nxt_state.match2 = 1'b0;
    end
  end

  // State register with documented reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
      state_ff.hreadyout <= 1'b1;
      state_ff.hresp <= CCPTS_HRESP_OKAY;
      state_ff.mode1 <= CCPTS_MODE_RST;
      state_ff.mode2 <= CCPTS_MODE_RST;
      state_ff.sel1 <= CCPTS_SEL_RST;
      state_ff.sel2 <= CCPTS_SEL_RST;
      state_ff.route <= CCPTS_ROUTE_RST;
      state_ff.val1 <= CCPTS_VAL_RST;
      state_ff.val2 <= CCPTS_VAL_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Every output straight from the state register
  assign hrdata = state_ff.hrdata;
  assign hreadyout = state_ff.hreadyout;
  assign hresp = state_ff.hresp;
  assign trig = state_ff.trig;
  assign unit_one_event_flag = state_ff.flag1;
  assign unit_two_event_flag = state_ff.flag2;

endmodule

// >>> ccpts_monitor.sv
// Port level assertions for the capture and timer select block
`timescale 1ns/10ps
module ccpts_monitor
  import ccpts_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer_two_period,
  input wire ccpts_pkg::ccpts_trig_type trig,
  input wire logic unit_one_event_flag,
  input wire logic unit_two_event_flag
);
  logic wf_ff;
  logic nxt_wf;

  // Flag register write now in its data phase; only then may a flag drop
  assign nxt_wf = hsel && htrans[1] && hready && hwrite &&
    hsize == CCPTS_HSIZE_WORD && haddr[7:0] == CCPTS_FLAG_OFS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wf_ff <= 1'b0;
    end else begin
      wf_ff <= nxt_wf;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hold1;
    unit_one_event_flag && !(wf_ff && hwdata[CCPTS_FLAG1_BIT]);
  endsequence
  sequence s_hold2;
    unit_two_event_flag && !(wf_ff && hwdata[CCPTS_FLAG2_BIT]);
  endsequence

  a_flag1_sticky: assert property (s_hold1 |=> unit_one_event_flag)
    else $error("unit one flag dropped without a clear");
  a_flag2_sticky: assert property (s_hold2 |=> unit_two_event_flag)
    else $error("unit two flag dropped without a clear");
  a_one_reset_pulse: assert property ($rose(trig.timer_one_reset)
    |=> !trig.timer_one_reset) else $error("timer one reset too long");
  a_three_reset_pulse: assert property ($rose(trig.timer_three_reset)
    |=> !trig.timer_three_reset) else $error("timer three reset too long");
  a_adc_with_reset: assert property (trig.adc_start |->
    trig.timer_one_reset || trig.timer_three_reset)
    else $error("conversion start without a timer reset");
  a_pwm_from_period: assert property (trig.pwm_period_update
    |-> $past(timer_two_period)) else $error("update without period");
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (hresp == CCPTS_HRESP_OKAY)
    else $error("slave answered with an error");
endmodule

bind ccpts_top ccpts_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .timer_two_period(timer_two_period), .trig(trig),
  .unit_one_event_flag(unit_one_event_flag),
  .unit_two_event_flag(unit_two_event_flag));

// >>> ccpts_edge_src.sv
// External edge source standing on one capture pin pad
`timescale 1ns/10ps
module ccpts_edge_src (
  input wire logic hclk,
  output logic pad
);
  initial pad = 1'b0;

  // edges follow system clock
  // Gap sets prompt or slow pulses; low level is held between pulses
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge hclk);
      pad <= 1'b1;
      repeat (gap) @(posedge hclk);
      pad <= 1'b0;
      repeat (gap) @(posedge hclk);
    end
  endtask
endmodule

// >>> test_ccp_capture_timer_select.sv
// Self-checking bench for the capture and timer select block
`timescale 1ns/10ps
module test_ccp_capture_timer_select;
  import ccpts_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic t2p, a_lat, a_dir, f1, f2, p1, pp, pa;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] t1, t3;
  ccpts_trig_type trig, acc;
  int failures, num_checks, cyc;

  assign hready = hreadyout;
  ccpts_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .unit_one_pin({p1, 2'b00}),
    .primary_port_pin({pp, 2'b00}), .alternate_port_pin({pa, a_lat, a_dir}),
    .timer_one_count(t1), .timer_three_count(t3), .timer_two_period(t2p),
    .trig(trig), .unit_one_event_flag(f1), .unit_two_event_flag(f2));
  ccpts_edge_src u_s1 (.hclk(hclk), .pad(p1));
  ccpts_edge_src u_sp (.hclk(hclk), .pad(pp));
  ccpts_edge_src u_sa (.hclk(hclk), .pad(pa));

  // Clock of 100 ns period
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Hang guard, far above the several hundred cycles the tests take
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end

  task automatic check32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Flags are looked at mid cycle, after the edge's updates land
  task automatic check1(input logic e, input bit is2);
    @(negedge hclk);
    check32({31'h0, is2 ? f2 : f1}, {31'h0, e});
  endtask

  // One single AHB-Lite word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= CCPTS_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  // Pin to flag takes up to four cycles; six leaves margin
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  task automatic watch(input int n);
    acc = '0;
    repeat (n) begin
      @(negedge hclk);
      acc = acc | trig;
    end
  endtask

  task automatic t_reset();
    ahb(1'b0, CCPTS_CTRL_OFS, 0);
    check32(rd, 32'h400);
    ahb(1'b0, 8'h14, 0);
    check32(rd, 0);
    check1(1'b0, 0);
    $display("t_reset done");
  endtask

  // Every capture mode of unit one, alternating its timer
  task automatic t_modes();
    logic [3:0] m [4] = '{CCPTS_CAP_FALL, CCPTS_CAP_RISE,
      CCPTS_CAP_DIV4, CCPTS_CAP_DIV16};
    int n [4] = '{1, 1, 4, 16};
    for (int i = 0; i < 4; i++) begin
      wr(CCPTS_CTRL_OFS, {22'h1, 1'b0, i[0], 4'h0, m[i]});
      wr(CCPTS_FLAG_OFS, 32'h3);
      u_s1.pulses(n[i] - 1, 2);
      settle();
      check1(1'b0, 0);
      u_s1.pulses(1, 2);
      settle();
      check1(1'b1, 0);
      ahb(1'b0, CCPTS_VAL1_OFS, 0);
      check32(rd, {16'h0, i[0] ? t3 : t1});
      wr(CCPTS_FLAG_OFS, 32'h1);
      check1(1'b0, 0);
      wr(CCPTS_CTRL_OFS, 32'h400);
    end
    $display("t_modes done");
  endtask

  task automatic t_overwrite();
    wr(CCPTS_CTRL_OFS, 32'h405);
    wr(CCPTS_FLAG_OFS, 32'h3);
    t1 <= 16'h1111;
    u_s1.pulses(1, 2);
    settle();
    t1 <= 16'h2222;
    u_s1.pulses(1, 2);
    settle();
    ahb(1'b0, CCPTS_VAL1_OFS, 0);
    check32(rd, 32'h2222);
    wr(CCPTS_FLAG_OFS, 32'h0);
    check1(1'b1, 0);
    wr(CCPTS_CTRL_OFS, 32'h400);
    $display("t_overwrite done");
  endtask

  // Two edges counted at divide by four carry over into sixteen
  task automatic t_switch();
    wr(CCPTS_CTRL_OFS, 32'h406);
    wr(CCPTS_FLAG_OFS, 32'h3);
    u_s1.pulses(2, 2);
    wr(CCPTS_CTRL_OFS, 32'h407);
    wr(CCPTS_FLAG_OFS, 32'h3);
    u_s1.pulses(13, 2);
    settle();
    check1(1'b0, 0);
    u_s1.pulses(1, 2);
    settle();
    check1(1'b1, 0);
    wr(CCPTS_CTRL_OFS, 32'h400);
    $display("t_switch done");
  endtask

  // Leaving capture, or a reset in mid-run, restarts the prescaler
  task automatic t_clear();
    wr(CCPTS_CTRL_OFS, 32'h406);
    u_s1.pulses(2, 2);
    wr(CCPTS_CTRL_OFS, 32'h400);
    wr(CCPTS_CTRL_OFS, 32'h406);
    wr(CCPTS_FLAG_OFS, 32'h3);
    u_s1.pulses(3, 2);
    settle();
    check1(1'b0, 0);
    u_s1.pulses(1, 2);
    settle();
    check1(1'b1, 0);
    u_s1.pulses(2, 2);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check1(1'b0, 0);
    ahb(1'b0, CCPTS_CTRL_OFS, 0);
    check32(rd, 32'h400);
    wr(CCPTS_CTRL_OFS, 32'h406);
    u_s1.pulses(3, 2);
    settle();
    check1(1'b0, 0);
    u_s1.pulses(1, 2);
    settle();
    check1(1'b1, 0);
    wr(CCPTS_CTRL_OFS, 32'h400);
    $display("t_clear done");
  endtask

  // Both units capture together from the one shared timer three
  task automatic t_share();
    wr(CCPTS_CTRL_OFS, 32'h755);
    wr(CCPTS_FLAG_OFS, 32'h3);
    ahb(1'b0, CCPTS_STAT_OFS, 0);
    check32(rd, 32'h3);
    fork
      u_s1.pulses(1, 2);
      u_sp.pulses(1, 2);
    join
    settle();
    check1(1'b1, 0);
    check1(1'b1, 1);
    ahb(1'b0, CCPTS_VAL1_OFS, 0);
    check32(rd, {16'h0, t3});
    ahb(1'b0, CCPTS_VAL2_OFS, 0);
    check32(rd, {16'h0, t3});
    wr(CCPTS_CTRL_OFS, 32'h400);
    wr(CCPTS_FLAG_OFS, 32'h3);
    $display("t_share done");
  endtask

  task automatic t_route();
    wr(CCPTS_CTRL_OFS, 32'h650);
    wr(CCPTS_FLAG_OFS, 32'h3);
    u_sa.pulses(1, 4);
    settle();
    check1(1'b0, 1);
    u_sp.pulses(1, 4);
    settle();
    check1(1'b1, 1);
    ahb(1'b0, CCPTS_VAL2_OFS, 0);
    check32(rd, {16'h0, t3});
    wr(CCPTS_CTRL_OFS, 32'h250);
    wr(CCPTS_FLAG_OFS, 32'h3);
    u_sp.pulses(1, 2);
    settle();
    check1(1'b0, 1);
    a_dir <= 1'b1;
    @(posedge hclk);
    a_lat <= 1'b1;
    settle();
    check1(1'b1, 1);
    a_dir <= 1'b0;
    a_lat <= 1'b0;
    wr(CCPTS_FLAG_OFS, 32'h3);
    u_sa.pulses(1, 2);
    settle();
    check1(1'b1, 1);
    $display("t_route done");
  endtask

  task automatic t_trigger();
    wr(CCPTS_CTRL_OFS, 32'h400);
    wr(CCPTS_VAL2_OFS, {16'h0, t1});
    wr(CCPTS_CTRL_OFS, 32'h4b0);
    watch(8);
    check32({28'h0, acc}, 32'ha);
    wr(CCPTS_CTRL_OFS, 32'h400);
    wr(CCPTS_VAL1_OFS, {16'h0, t3});
    wr(CCPTS_CTRL_OFS, 32'h50b);
    watch(8);
    check32({28'h0, acc}, 32'h4);
    wr(CCPTS_CTRL_OFS, 32'h4cc);
    ahb(1'b0, CCPTS_STAT_OFS, 0);
    check32(rd, 32'h30);
    @(posedge hclk);
    t2p <= 1'b1;
    @(posedge hclk);
    t2p <= 1'b0;
    watch(4);
    check32({28'h0, acc}, 32'h1);
    // Flag-only compare match raises no trigger at all
    wr(CCPTS_CTRL_OFS, 32'h400);
    wr(CCPTS_VAL1_OFS, {16'h0, t1});
    wr(CCPTS_FLAG_OFS, 32'h3);
    wr(CCPTS_CTRL_OFS, 32'h40a);
    watch(8);
    check32({28'h0, acc}, 32'h0);
    check1(1'b1, 0);
    ahb(1'b0, CCPTS_STAT_OFS, 0);
    check32(rd, 32'h4);
    $display("t_trigger done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reset for four cycles, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    t1 = 16'h1234;
    t3 = 16'habcd;
    t2p = 1'b0;
    a_lat = 1'b0;
    a_dir = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modes();
    t_overwrite();
    t_switch();
    t_clear();
    t_route();
    t_share();
    t_trigger();
    final_report();
  end
endmodule
